/* File: common/dwt_pkg.sv */
// shared constants and types for the write turnaround command scheduler
package dwt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LAT  = 8'h04;
  localparam logic [7:0] A_TNRM = 8'h08;
  localparam logic [7:0] A_TDBI = 8'h0c;
  localparam logic [7:0] A_TCDM = 8'h10;
  localparam logic [7:0] A_CMD  = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DBI   = 2;
  localparam int CTRL_CRC   = 3;
  localparam int CTRL_DM    = 4;
  localparam int CTRL_WPRE2 = 5;
  localparam int CMD_A12    = 2;
  localparam int CMD_BG     = 3;
  localparam int CMD_FORCE  = 4;
  localparam int CMD_SKEW   = 5;
  localparam int STAT_CLR   = 1;
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [15:0] LAT_RST  = 16'h090b;
  localparam logic [23:0] TIM_RST  = 24'h000000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [15:0] LINK_TCK_PS = 16'h7530;
  localparam logic [9:0]  PS_PER_NS   = 10'h3e8;
  localparam logic [3:0]  TOL_EDGES   = 4'h6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BM_FIX8 = 2'h0,
    BM_OTF  = 2'h1,
    BM_CHOP = 2'h2
  } dwt_mode_e;

  typedef enum logic [1:0] {
    OP_RD  = 2'h0,
    OP_WR  = 2'h1,
    OP_PRE = 2'h2
  } dwt_op_e;

  typedef struct packed {
    logic [1:0] op;
    logic       a12;
    logic       bg;
    logic       force_issue;
    logic [3:0] skew;
    logic [1:0] mode;
    logic       crc;
    logic       wpre2;
    logic [7:0] cl;
    logic [7:0] cwl;
    logic [7:0] wtr_l;
    logic [7:0] wtr_s;
    logic [7:0] wr;
  } dwt_cmd_s;

endpackage : dwt_pkg

/* File: design/dwt_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dwt_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dwt_sync_s;

  dwt_sync_s st_reg;
  dwt_sync_s st_next;

  // no reset: the stages settle within two edges of a running clock
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign q = st_reg.s2;
endmodule : dwt_sync
`default_nettype wire

/* File: design/dwt_axil.sv */
// axi4-lite slave front end: write strobe out, read data in
`timescale 1ns/1ps
`default_nettype none
module dwt_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        stb;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        arready;
    logic        rd_pend;
    logic        rvalid;
    logic [7:0]  raddr;
    logic [31:0] rdata;
  } dwt_axil_s;

  dwt_axil_s s_reg;
  dwt_axil_s s_next;

  always_comb begin
    s_next     = s_reg;
    s_next.stb = 1'b0;
    if (awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.waddr  = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    // response only once both halves are in, in either order
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.stb    = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid && !s_next.stb;
    s_next.wready  = !s_next.w_got && !s_next.bvalid && !s_next.stb;
    if (arvalid && s_reg.arready) begin
      s_next.raddr   = araddr;
      s_next.rd_pend = 1'b1;
      s_next.arready = 1'b0;
    end
    if (s_reg.rd_pend) begin
      s_next.rdata   = rd_data;
      s_next.rvalid  = 1'b1;
      s_next.rd_pend = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg         <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready  <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready  = s_reg.wready;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = 2'h0;
  assign arready = s_reg.arready;
  assign rvalid  = s_reg.rvalid;
  assign rdata   = s_reg.rdata;
  assign rresp   = 2'h0;
  assign wr_stb  = s_reg.stb;
  assign wr_addr = s_reg.waddr;
  assign wr_data = s_reg.wdata;
  assign wr_strb = s_reg.wstrb;
  assign rd_addr = s_reg.raddr;
endmodule : dwt_axil
`default_nettype wire

/* File: design/dwt_ctrl.sv */
// write/read turnaround command scheduler, host side of the memory link
//
// Summary of operation
// - fixed eight mode, or A12 high on the fly: eight beats
// - fixed chop mode: every burst four beats
// - read to write: CL-CWL+RBL/2+1+preamble
// - read length eight, or four when chopped
// - write length four only in fixed chop
// - recovery counted from edge after last beat
// - inversion on: use inversion timing set
// - crc with mask on: use that timing set (code takes the inversion set when inversion is also on)
// - untolerated violation demands full reinitialisation
// - tolerance needs crc off, on-the-fly off
// - strobe within six edges of nominal position
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        lk_clk,
  output logic             lk_cmd_stb,
  output logic [1:0]       lk_cmd_op,
  output logic             lk_a12,
  output logic             lk_bg,
  output logic             lk_chop
);

  // ----------------------------------------------------------------
  // state of the bus clock side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]       ctrl;
    logic [15:0]      lat;
    logic [23:0]      tnrm;
    logic [23:0]      tdbi;
    logic [23:0]      tcdm;
    dwt_pkg::dwt_cmd_s bnd;
    logic             req_tgl;
    logic             ack_seen;
    logic             busy;
    logic             need_reinit;
    logic             last_viol;
    logic             last_tol;
    logic             suspect;
    logic [7:0]       ncmds;
  } dwt_bus_s;

  // ----------------------------------------------------------------
  // state of the link clock side
  // ----------------------------------------------------------------
  typedef enum logic {
    L_IDLE = 1'b0,
    L_WAIT = 1'b1
  } dwt_lst_e;

  typedef struct packed {
    dwt_lst_e          st;
    logic              req_seen;
    logic              ack_tgl;
    dwt_pkg::dwt_cmd_s cur;
    logic              viol;
    logic              tol;
    logic              suspect;
    logic [7:0]        since_rd;
    logic [7:0]        since_wr;
    logic              have_rd;
    logic              have_wr;
    logic              rd_chop;
    logic              wr_chop4;
    logic              wr_bg;
    logic              stb;
    logic [1:0]        op;
    logic              a12;
    logic              bg;
    logic              chop;
  } dwt_link_s;

  dwt_bus_s  b_reg;
  dwt_bus_s  b_next;
  dwt_link_s l_reg;
  dwt_link_s l_next;

  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        req_sync;
  logic        ack_sync;
  logic        lk_rst_n;

  // ----------------------------------------------------------------
  // bus slave and crossings
  // ----------------------------------------------------------------
  dwt_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // reset enters the link domain as a level
  dwt_sync #(.W(1)) u_rst_sync (
    .clk (lk_clk),
    .d   (aresetn),
    .q   (lk_rst_n)
  );

  // request toggle; the bundle is held stable until the ack returns
  dwt_sync #(.W(1)) u_req_sync (
    .clk (lk_clk),
    .d   (b_reg.req_tgl),
    .q   (req_sync)
  );

  dwt_sync #(.W(1)) u_ack_sync (
    .clk (aclk),
    .d   (l_reg.ack_tgl),
    .q   (ack_sync)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction : merge

  always_comb begin
    rd_data = 32'h00000000;
    unique case (rd_addr)
      dwt_pkg::A_CTRL: rd_data = {26'h0, b_reg.ctrl};
      dwt_pkg::A_LAT:  rd_data = {16'h0, b_reg.lat};
      dwt_pkg::A_TNRM: rd_data = {8'h0, b_reg.tnrm};
      dwt_pkg::A_TDBI: rd_data = {8'h0, b_reg.tdbi};
      dwt_pkg::A_TCDM: rd_data = {8'h0, b_reg.tcdm};
      dwt_pkg::A_STAT: rd_data = {16'h0, b_reg.ncmds, 3'h0,
                                  b_reg.suspect, b_reg.last_viol,
                                  b_reg.last_tol, b_reg.need_reinit,
                                  b_reg.busy};
      default:         rd_data = 32'h00000000;
    endcase
  end

  always_comb begin
    logic [31:0] m;
    logic [23:0] tset;
    m      = merge(32'h0, wr_data, wr_strb);
    tset   = b_reg.tnrm;
    b_next = b_reg;
    if (b_reg.ctrl[dwt_pkg::CTRL_DBI]) begin
      tset = b_reg.tdbi;
    end else if (b_reg.ctrl[dwt_pkg::CTRL_CRC] &&
                 b_reg.ctrl[dwt_pkg::CTRL_DM]) begin
      tset = b_reg.tcdm;
    end
    if (wr_stb) begin
      unique case (wr_addr)
        dwt_pkg::A_CTRL: begin
          b_next.ctrl = 6'(merge({26'h0, b_reg.ctrl}, wr_data, wr_strb));
        end
        dwt_pkg::A_LAT: begin
          b_next.lat = 16'(merge({16'h0, b_reg.lat}, wr_data, wr_strb));
        end
        dwt_pkg::A_TNRM: begin
          b_next.tnrm = 24'(merge({8'h0, b_reg.tnrm}, wr_data, wr_strb));
        end
        dwt_pkg::A_TDBI: begin
          b_next.tdbi = 24'(merge({8'h0, b_reg.tdbi}, wr_data, wr_strb));
        end
        dwt_pkg::A_TCDM: begin
          b_next.tcdm = 24'(merge({8'h0, b_reg.tcdm}, wr_data, wr_strb));
        end
        dwt_pkg::A_CMD: begin
          // refused while busy or while a reinitialisation is owed
          if (wr_strb[0] && wr_strb[1] && !b_reg.busy &&
              !b_reg.need_reinit) begin
            b_next.bnd.op          = m[1:0];
            b_next.bnd.a12         = m[dwt_pkg::CMD_A12];
            b_next.bnd.bg          = m[dwt_pkg::CMD_BG];
            b_next.bnd.force_issue = m[dwt_pkg::CMD_FORCE];
            b_next.bnd.skew        = m[dwt_pkg::CMD_SKEW +: 4];
            b_next.bnd.mode        = b_reg.ctrl[1:0];
            b_next.bnd.crc         = b_reg.ctrl[dwt_pkg::CTRL_CRC];
            b_next.bnd.wpre2       = b_reg.ctrl[dwt_pkg::CTRL_WPRE2];
            b_next.bnd.cl          = b_reg.lat[7:0];
            b_next.bnd.cwl         = b_reg.lat[15:8];
            b_next.bnd.wtr_l       = tset[7:0];
            b_next.bnd.wtr_s       = tset[15:8];
            b_next.bnd.wr          = tset[23:16];
            b_next.req_tgl         = !b_reg.req_tgl;
            b_next.busy            = 1'b1;
          end
        end
        dwt_pkg::A_STAT: begin
          if (m[dwt_pkg::STAT_CLR]) begin
            b_next.need_reinit = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // ack after the clear so a fresh violation is never lost
    if (ack_sync != b_reg.ack_seen) begin
      b_next.ack_seen  = ack_sync;
      b_next.busy      = 1'b0;
      b_next.last_viol = l_reg.viol;
      b_next.last_tol  = l_reg.tol;
      b_next.suspect   = l_reg.suspect;
      b_next.ncmds     = b_reg.ncmds + 8'h01;
      if (l_reg.viol && !l_reg.tol) begin
        b_next.need_reinit = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_reg      <= '0;
      b_reg.ctrl <= dwt_pkg::CTRL_RST;
      b_reg.lat  <= dwt_pkg::LAT_RST;
      b_reg.tnrm <= dwt_pkg::TIM_RST;
      b_reg.tdbi <= dwt_pkg::TIM_RST;
      b_reg.tcdm <= dwt_pkg::TIM_RST;
    end else begin
      b_reg <= b_next;
    end
  end

  // ----------------------------------------------------------------
  // link side spacing checks
  // ----------------------------------------------------------------
  logic [7:0]  rtw_need;
  logic [7:0]  wdone;
  logic [7:0]  after_w;
  logic [7:0]  need_ns;
  logic [23:0] el_ps;
  logic [23:0] ns_ps;
  logic        wok;
  logic        met;
  logic        tol;
  logic        chop;

  always_comb begin
    // read length is four only when the read itself was chopped
    rtw_need = l_reg.cur.cl - l_reg.cur.cwl +
               (l_reg.rd_chop ? 8'h02 : 8'h04) + 8'h01 +
               (l_reg.cur.wpre2 ? 8'h02 : 8'h01);
    // cycles to the first edge after the last write beat
    wdone   = l_reg.cur.cwl + (l_reg.wr_chop4 ? 8'h02 : 8'h04);
    after_w = (l_reg.since_wr >= wdone) ? 8'(l_reg.since_wr - wdone)
                                        : 8'h00;
    need_ns = l_reg.cur.wr;
    if (l_reg.cur.op == dwt_pkg::OP_RD) begin
      need_ns = (l_reg.cur.bg == l_reg.wr_bg) ? l_reg.cur.wtr_l
                                              : l_reg.cur.wtr_s;
    end
    // comparing in picoseconds rounds the ns term up to whole cycles
    el_ps = 24'(after_w) * 24'(dwt_pkg::LINK_TCK_PS);
    ns_ps = 24'(need_ns) * 24'(dwt_pkg::PS_PER_NS);
    wok   = !l_reg.have_wr || (l_reg.since_wr >= wdone && el_ps >= ns_ps);
    unique case (l_reg.cur.op)
      dwt_pkg::OP_RD:  met = wok;
      dwt_pkg::OP_WR:  met = !l_reg.have_rd || l_reg.since_rd >= rtw_need;
      dwt_pkg::OP_PRE: met = wok;
      default:         met = 1'b1;
    endcase
    tol  = !l_reg.cur.crc && l_reg.cur.mode != dwt_pkg::BM_OTF
           && l_reg.cur.skew <= dwt_pkg::TOL_EDGES;
    chop = l_reg.cur.mode == dwt_pkg::BM_CHOP ||
           (l_reg.cur.mode == dwt_pkg::BM_OTF && !l_reg.cur.a12);
  end

  // ----------------------------------------------------------------
  // link side issue state machine
  // ----------------------------------------------------------------
  always_comb begin
    l_next     = l_reg;
    l_next.stb = 1'b0;
    if (l_reg.since_rd != 8'hff) begin
      l_next.since_rd = l_reg.since_rd + 8'h01;
    end
    if (l_reg.since_wr != 8'hff) begin
      l_next.since_wr = l_reg.since_wr + 8'h01;
    end
    unique case (l_reg.st)
      L_IDLE: begin
        if (req_sync != l_reg.req_seen) begin
          l_next.req_seen = req_sync;
          l_next.cur      = b_reg.bnd;
          l_next.st       = L_WAIT;
        end
      end
      L_WAIT: begin
        // a forced issue is the only way a spacing can be violated
        if (met || l_reg.cur.force_issue) begin
          l_next.stb     = 1'b1;
          l_next.op      = l_reg.cur.op;
          l_next.a12     = l_reg.cur.a12;
          l_next.bg      = l_reg.cur.bg;
          l_next.chop    = chop;
          l_next.viol    = !met;
          l_next.tol     = tol;
          l_next.ack_tgl = !l_reg.ack_tgl;
          l_next.st      = L_IDLE;
          unique case (l_reg.cur.op)
            dwt_pkg::OP_RD: begin
              // reads after an offending write are still issued
              l_next.since_rd = 8'h00;
              l_next.have_rd  = 1'b1;
              l_next.rd_chop  = chop;
            end
            dwt_pkg::OP_WR: begin
              l_next.since_wr = 8'h00;
              l_next.have_wr  = 1'b1;
              l_next.wr_chop4 = l_reg.cur.mode == dwt_pkg::BM_CHOP;
              l_next.wr_bg    = l_reg.cur.bg;
              // later writes land but their data stays suspect
              l_next.suspect  = l_reg.suspect || !met;
            end
            dwt_pkg::OP_PRE: begin
              l_next.suspect = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge lk_clk) begin
    if (!lk_rst_n) begin
      l_reg    <= '0;
      l_reg.st <= L_IDLE;
    end else begin
      l_reg <= l_next;
    end
  end

  assign lk_cmd_stb = l_reg.stb;
  assign lk_cmd_op  = l_reg.op;
  assign lk_a12     = l_reg.a12;
  assign lk_bg      = l_reg.bg;
  assign lk_chop    = l_reg.chop;

endmodule : dwt_ctrl
`default_nettype wire

/* File: tb/dwt_ctrl_checker.sv */
// assertions on the scheduler's bus and link ports
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        lk_clk,
  input wire logic        lk_cmd_stb,
  input wire logic [1:0]  lk_cmd_op,
  input wire logic        lk_bg
);
  // --------------------
  // bus side
  // --------------------
  bresp_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bresp not okay");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r dropped");
  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("b late");
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("r late");
  wr_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // --------------------
  // link side
  // --------------------
  stb_pulse_a: assert property (@(posedge lk_clk) disable iff (!aresetn)
    lk_cmd_stb |=> !lk_cmd_stb) else $error("stb too long");
  cmd_held_a: assert property (@(posedge lk_clk) disable iff (!aresetn)
    !lk_cmd_stb |-> $stable(lk_cmd_op) && $stable(lk_bg))
    else $error("cmd moved");
endmodule : dwt_ctrl_checker
bind dwt_ctrl dwt_ctrl_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .lk_clk, .lk_cmd_stb, .lk_cmd_op, .lk_bg);
`default_nettype wire

/* File: tb/dwt_mem_model.sv */
// behavioural memory device watching issued commands
`timescale 1ns/1ps
`default_nettype none
module dwt_mem_model (
  input  wire logic        lk_clk,
  input  wire logic        lk_cmd_stb,
  input  wire logic [1:0]  lk_cmd_op,
  input  wire logic        lk_chop,
  output logic      [15:0] gap,
  output logic      [1:0]  op,
  output logic             chop,
  output logic      [15:0] count
);
  logic [15:0] run = 16'h0001;
  initial {gap, op, chop, count} = 35'h0;
  // every command is accepted, offending or not; stored data not modelled
  always @(posedge lk_clk) begin
    run <= run + 16'h0001;
    if (lk_cmd_stb) begin
      run <= 16'h0001;
      gap <= run;
      op <= lk_cmd_op;
      chop <= lk_chop;
      count <= count + 16'h0001;
    end
  end
endmodule : dwt_mem_model
`default_nettype wire

/* File: tb/dwt_ctrl_bench.sv */
// self-checking bench for the turnaround scheduler
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl_bench;
  logic        aclk = 1'b0, lk_clk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, stb, a12, bg, chop;
  logic [1:0]  bresp, rresp, op, m_op;
  logic [15:0] m_gap, m_cnt;
  logic        m_chop;
  int          fails = 0, cmp_count = 0;
  always #10 aclk = ~aclk;
  // offset keeps the link clock out of step with the bus clock
  initial begin
    #7;
    forever #15 lk_clk = ~lk_clk;
  end
  dwt_ctrl u_dwt_ctrl (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lk_clk,
    .lk_cmd_stb(stb), .lk_cmd_op(op), .lk_a12(a12), .lk_bg(bg),
    .lk_chop(chop));
  dwt_mem_model u_dwt_mem_model (.lk_clk, .lk_cmd_stb(stb),
    .lk_cmd_op(op), .lk_chop(chop), .gap(m_gap), .op(m_op), .chop(m_chop),
    .count(m_cnt));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    chk("rresp", rresp, 2'h0);
    rready <= 1'b0;
  endtask : axr
  task automatic cmd(input logic [1:0] o, input logic a, b, f,
                     input logic [3:0] s);
    axw(dwt_pkg::A_CMD, {23'h0, s, f, b, a, o});
    do axr(dwt_pkg::A_STAT, rd);
    while (rd[0] !== 1'b0);
  endtask : cmd
  task automatic pair(input logic [31:0] ctl, input logic [1:0] o1, o2,
                      input logic a, b, input int n);
    axw(dwt_pkg::A_CTRL, ctl);
    cmd(o1, a, 1'b0, 1'b0, 4'h0);
    cmd(o2, a, b, 1'b0, 4'h0);
    chk("gap", m_gap >= n && m_gap <= n + 2, 1);
    chk("op", m_op, o2);
    chk("bg", bg, b);
    chk("a12", a12, a);
    if (o2 != 2'h2) chk("chop", m_chop, ctl[1] | (ctl[0] & ~a));
  endtask : pair
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      axr(8'(i * 4), rd);
      chk("reset", rd, (i == 1) ? 32'(dwt_pkg::LAT_RST) : 32'h0);
    end
    axw(8'h40, 32'h5a5a5a5a);
    axr(8'h40, rd);
    chk("unmapped", rd, 32'h0);
    axw(dwt_pkg::A_LAT, 32'h00001234);
    axr(dwt_pkg::A_LAT, rd);
    chk("lat", rd, 32'h00001234);
  endtask : t_regs
  task automatic t_rd_wr;
    axw(dwt_pkg::A_LAT, 32'h0a28);
    pair(32'h00, 2'h0, 2'h1, 1'b0, 1'b0, 36);
    pair(32'h02, 2'h0, 2'h1, 1'b0, 1'b0, 34);
    pair(32'h01, 2'h0, 2'h1, 1'b0, 1'b0, 34);
    pair(32'h01, 2'h0, 2'h1, 1'b1, 1'b0, 36);
    pair(32'h20, 2'h0, 2'h1, 1'b0, 1'b0, 37);
  endtask : t_rd_wr
  task automatic t_wr_rd;
    // cl must exceed cwl, else the read to write spacing wraps
    axw(dwt_pkg::A_LAT, 32'h1e28);
    axw(dwt_pkg::A_TNRM, 32'h003d643c);
    axw(dwt_pkg::A_TDBI, 32'h00009696);
    axw(dwt_pkg::A_TCDM, 32'h0000c8c8);
    pair(32'h00, 2'h1, 2'h0, 1'b0, 1'b0, 36);
    pair(32'h00, 2'h1, 2'h0, 1'b0, 1'b1, 38);
    pair(32'h01, 2'h1, 2'h0, 1'b0, 1'b0, 36);
    pair(32'h02, 2'h1, 2'h0, 1'b0, 1'b0, 34);
    pair(32'h04, 2'h1, 2'h0, 1'b0, 1'b0, 39);
    pair(32'h18, 2'h1, 2'h0, 1'b0, 1'b0, 41);
    pair(32'h1c, 2'h1, 2'h0, 1'b0, 1'b0, 39);
    pair(32'h00, 2'h1, 2'h2, 1'b0, 1'b0, 37);
  endtask : t_wr_rd
  task automatic viol(input logic [31:0] ctl, input logic [3:0] s,
                      input logic [1:0] e);
    axw(dwt_pkg::A_CTRL, ctl);
    cmd(2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    cmd(2'h1, 1'b1, 1'b0, 1'b1, s);
    axr(dwt_pkg::A_STAT, rd);
    chk("viol", rd[2:1], e);
  endtask : viol
  task automatic t_viol;
    logic [15:0] c;
    axw(dwt_pkg::A_LAT, 32'h0a28);
    viol(32'h00, 4'h7, 2'b01);
    c = m_cnt;
    cmd(2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    chk("refused", m_cnt, c);
    axw(dwt_pkg::A_STAT, 32'h2);
    axr(dwt_pkg::A_STAT, rd);
    chk("cleared", rd[1], 1'b0);
    viol(32'h00, 4'h6, 2'b10);
    chk("count", m_cnt, c + 16'h0002);
    viol(32'h01, 4'h0, 2'b01);
    axw(dwt_pkg::A_STAT, 32'h2);
    viol(32'h08, 4'h0, 2'b01);
    axw(dwt_pkg::A_STAT, 32'h2);
  endtask : t_viol
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_rd_wr;
    t_wr_rd;
    t_viol;
    finish_test;
  end
  initial begin
    #1500000;
    fails++;
    finish_test;
  end
endmodule : dwt_ctrl_bench
`default_nettype wire
